/* File: hw/itw_pkg.sv */
// ==========================================================
// Interval timer and watchdog shared definitions
package itw_pkg;
	// ==========================================================
	// Register file map, 4-bit registers
	localparam logic [6:0] ITW_WATCHDOG_MODE_ADDR = 7'h03; // watchdog_mode
	localparam logic [6:0] ITW_INTERVAL_TIMER_MODE_ADDR = 7'h13; // interval_timer_mode
	localparam int ITW_RF_W = 4; // Register data width
	localparam logic [3:0] ITW_MODE_RESET = 4'h0; // Reset value of both registers
	// Field positions, interval_timer_mode
	localparam int ITW_POS_PULSE_LO = 0; // interval_pulse_select_lo
	localparam int ITW_POS_PULSE_HI = 1; // interval_pulse_select_hi
	localparam int ITW_POS_CNT_CLEAR = 2; // interval_counter_clear
	localparam int ITW_POS_LEN_SEL = 3; // interval_length_select
	// Field positions, watchdog_mode
	localparam int ITW_POS_WD_ENABLE = 0; // watchdog_enable_bit
	localparam int ITW_POS_WD_RESTART = 3; // watchdog_restart_bit
	// ==========================================================
	// Count pulse sources
	localparam logic [1:0] ITW_SRC_DIV_SLOW = 2'h0; // fcc/8192
	localparam logic [1:0] ITW_SRC_DIV_FAST = 2'h1; // fcc/4096
	localparam logic [1:0] ITW_SRC_TIMER0 = 2'h2; // Timer 0 count-up
	localparam logic [1:0] ITW_SRC_INT_PIN = 2'h3; // External interrupt pin
	localparam int ITW_DIV_SLOW = 8192; // Slow divider ratio
	localparam int ITW_DIV_FAST = 4096; // Fast divider ratio
	localparam int ITW_PRE_W = 13; // Prescaler width, covers the slow ratio
	localparam logic [12:0] ITW_PRE_SLOW_LAST = 13'(ITW_DIV_SLOW - 1);
	localparam logic [11:0] ITW_PRE_FAST_LAST = 12'(ITW_DIV_FAST - 1);
	// ==========================================================
	// Interval and watchdog counts
	localparam int ITW_CNT_W = 7; // Interval counter width
	localparam logic [6:0] ITW_CNT_LONG_LAST = 7'h7F; // 128 pulses
	localparam logic [4:0] ITW_CNT_SHORT_LAST = 5'h1F; // 32 pulses
	localparam logic [6:0] ITW_CNT_ZERO = 7'h00; // Cleared count
	localparam logic [6:0] ITW_CNT_ONE = 7'h01; // Count step
	localparam logic [6:0] ITW_WD_EXPIRE_LOW = 7'h40; // With scaler set: count 192
	// ==========================================================
	// Watchdog state, one-hot
	typedef enum logic [1:0] {
		ITW_WD_IDLE = 2'b01,
		ITW_WD_RUN = 2'b10
	} itw_wd_state_e;
	// Register file request
	typedef struct packed {
		logic wr; // Write strobe
		logic rd; // Read strobe
		logic [6:0] addr; // Register file address
		logic [3:0] wdata; // Write data
	} itw_rf_req_s;
endpackage : itw_pkg

/* File: hw/itw_timer.sv */
// Functional notes
// - Select codes 00/01 pick fcc/8192, fcc/4096
// - Codes 10/11 pick timer 0, interrupt pin
// - Counter clear bit clears counter, reads zero
// - Length select zero: interval every 128 pulses
// - Length select one: interval every 32 pulses
// - Enable write starts watchdog; zero never stops
// - Enable bit self-clears, running state held inside
// - Restart bit clears overflow carry flip-flop
// - Enable starts one-bit scaler, eight-bit count
// - Expiry at count 192 issues system reset, held until rst
// - Only device reset stops running watchdog
// - Repeated counter clears suppress interval completion
// - Enabling watchdog leaves interval counter untouched
`timescale 1ns/100ps
`default_nettype none
module itw_timer import itw_pkg::*; (
	input wire logic core_clk, // 200 MHz system clock
	input wire logic rst, // Synchronous, active high
	input wire itw_rf_req_s rf_req, // Register file access
	output logic [3:0] rf_rdata_ff, // Read data, one cycle after rd
	input wire logic tm0_count_up, // Timer 0 count-up pulse
	input wire logic int_pin, // External interrupt pin level
	input wire logic zero_cross_enable, // Route pin via zero-cross detector
	input wire logic zero_cross_out, // Zero-cross detector output level
	output logic interval_irq_ff, // One-cycle interval request
	output logic wd_running_ff, // Watchdog running status
	output logic wd_sys_reset_ff // System reset request, held until rst
);
	// ==========================================================
	// Register write decode
	logic wr_btm; // Write to interval_timer_mode
	logic wr_wdt; // Write to watchdog_mode
	logic cnt_clear; // Counter clear strobe
	logic wd_start; // Watchdog enable strobe
	logic wd_restart; // Scaler clear strobe
	always_comb begin
		wr_btm = 1'b0;
		wr_wdt = 1'b0;
		// Address decode
		if (rf_req.wr && rf_req.addr == ITW_INTERVAL_TIMER_MODE_ADDR) begin
			wr_btm = 1'b1;
		end else if (rf_req.wr && rf_req.addr == ITW_WATCHDOG_MODE_ADDR) begin
			wr_wdt = 1'b1;
		end
		// Self-clearing bits are strobes, never stored
		cnt_clear = wr_btm && rf_req.wdata[ITW_POS_CNT_CLEAR];
		wd_start = wr_wdt && rf_req.wdata[ITW_POS_WD_ENABLE];
		wd_restart = wr_wdt && rf_req.wdata[ITW_POS_WD_RESTART];
	end

	// ==========================================================
	// Mode bits and read port
	logic [1:0] pulse_sel_ff, nxt_pulse_sel; // Count pulse select
	logic len_sel_ff, nxt_len_sel; // interval_length_select
	logic [3:0] nxt_rf_rdata; // Next read data
	always_comb begin
		nxt_pulse_sel = pulse_sel_ff;
		nxt_len_sel = len_sel_ff;
		nxt_rf_rdata = ITW_MODE_RESET;
		if (wr_btm) begin
			nxt_pulse_sel = {rf_req.wdata[ITW_POS_PULSE_HI], rf_req.wdata[ITW_POS_PULSE_LO]};
			nxt_len_sel = rf_req.wdata[ITW_POS_LEN_SEL];
		end
		if (rf_req.rd && rf_req.addr == ITW_INTERVAL_TIMER_MODE_ADDR) begin
			// Clear bit always reads zero
			// clear reads zero
			nxt_rf_rdata[ITW_POS_LEN_SEL] = len_sel_ff;
			nxt_rf_rdata[ITW_POS_PULSE_HI] = pulse_sel_ff[1];
			nxt_rf_rdata[ITW_POS_PULSE_LO] = pulse_sel_ff[0];
		end
		// Watchdog register and unmapped addresses read all zero
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pulse_sel_ff <= 2'h0;
			len_sel_ff <= 1'b0;
			rf_rdata_ff <= ITW_MODE_RESET;
		end else begin
			pulse_sel_ff <= nxt_pulse_sel;
			len_sel_ff <= nxt_len_sel;
			rf_rdata_ff <= nxt_rf_rdata;
		end
	end

	// ==========================================================
	// Prescaler and count pulse selection
	logic [ITW_PRE_W-1:0] pre_ff, nxt_pre; // Free-running divider
	logic pin_prev_ff, nxt_pin_prev; // Last sampled pin level
	logic pin_level; // Pin or zero-cross output
	logic tick_slow; // fcc/8192 tick
	logic tick_fast; // fcc/4096 tick
	logic count_pulse; // Selected pulse this cycle
	always_comb begin
		nxt_pre = pre_ff + 13'h0001;
		tick_slow = (pre_ff == ITW_PRE_SLOW_LAST);
		tick_fast = (pre_ff[11:0] == ITW_PRE_FAST_LAST);
		pin_level = zero_cross_enable ? zero_cross_out : int_pin;
		nxt_pin_prev = pin_level;
		count_pulse = 1'b0;
		case (pulse_sel_ff)
			ITW_SRC_DIV_SLOW: count_pulse = tick_slow;
			ITW_SRC_DIV_FAST: count_pulse = tick_fast;
			ITW_SRC_TIMER0: count_pulse = tm0_count_up;
			// Rising edge counts; the pin is taken as synchronous
			default: count_pulse = pin_level && !pin_prev_ff;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pre_ff <= '0;
			pin_prev_ff <= 1'b0;
		end else begin
			pre_ff <= nxt_pre;
			pin_prev_ff <= nxt_pin_prev;
		end
	end

	// ==========================================================
	// Interval counter, scaler and watchdog
	logic [ITW_CNT_W-1:0] cnt_ff, nxt_cnt; // basic_interval_counter
	logic scaler_ff, nxt_scaler; // Overflow carry flip-flop
	itw_wd_state_e wd_state_ff, nxt_wd_state; // Watchdog state
	logic nxt_irq; // Next interval request
	logic nxt_wd_reset; // Next system reset request
	logic cnt_step; // Counter advances
	logic carry; // Counter wraps past 127
	logic expire; // Eight-bit count at 192
	always_comb begin
		nxt_wd_state = wd_state_ff;
		nxt_cnt = cnt_ff;
		nxt_scaler = scaler_ff;
		// A clear beats a coinciding pulse, so an interval in flight never completes
		cnt_step = count_pulse && !cnt_clear;
		carry = cnt_step && cnt_ff == ITW_CNT_LONG_LAST;
		if (cnt_clear) begin
			nxt_cnt = ITW_CNT_ZERO;
		end else if (cnt_step) begin
			nxt_cnt = cnt_ff + ITW_CNT_ONE;
		end
		nxt_irq = cnt_step && (len_sel_ff ? cnt_ff[4:0] == ITW_CNT_SHORT_LAST : carry);
		case (wd_state_ff)
			ITW_WD_IDLE: if (wd_start) nxt_wd_state = ITW_WD_RUN;
			default: nxt_wd_state = ITW_WD_RUN;
		endcase
		// scaler only while running; carry wins over restart
		if (wd_state_ff == ITW_WD_RUN && carry) begin
			nxt_scaler = 1'b1;
		end else if (wd_restart) begin
			nxt_scaler = 1'b0;
		end
		expire = wd_state_ff == ITW_WD_RUN && scaler_ff && cnt_ff == ITW_WD_EXPIRE_LOW;
		nxt_wd_reset = wd_sys_reset_ff || expire;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_ff <= ITW_CNT_ZERO;
			scaler_ff <= 1'b0;
			wd_state_ff <= ITW_WD_IDLE;
			wd_running_ff <= 1'b0;
			interval_irq_ff <= 1'b0;
			wd_sys_reset_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			scaler_ff <= nxt_scaler;
			wd_state_ff <= nxt_wd_state;
			wd_running_ff <= (nxt_wd_state == ITW_WD_RUN);
			interval_irq_ff <= nxt_irq;
			wd_sys_reset_ff <= nxt_wd_reset;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence seq_enable_write;
		wd_start && !count_pulse && !cnt_clear;
	endsequence
	sequence seq_running_hold;
		wd_running_ff [*4];
	endsequence
	chk_clear_counter: assert property (cnt_clear |=> cnt_ff == ITW_CNT_ZERO)
		else $error("counter not cleared");
	chk_slow_source: assert property (
		(pulse_sel_ff == ITW_SRC_DIV_SLOW && count_pulse) |-> pre_ff == ITW_PRE_SLOW_LAST)
		else $error("slow pulse off divider");
	chk_timer0_step: assert property (
		(pulse_sel_ff == ITW_SRC_TIMER0 && tm0_count_up && !cnt_clear)
		|=> cnt_ff == $past(cnt_ff) + ITW_CNT_ONE)
		else $error("timer 0 pulse not counted");
	chk_long_irq: assert property (
		(!len_sel_ff && cnt_step && cnt_ff == ITW_CNT_LONG_LAST)
		|=> interval_irq_ff && cnt_ff == ITW_CNT_ZERO)
		else $error("128 interval missing");
	chk_short_irq: assert property (
		interval_irq_ff && $past(len_sel_ff) |-> $past(cnt_ff[4:0]) == ITW_CNT_SHORT_LAST)
		else $error("32 interval wrong");
	chk_wd_start: assert property (
		seq_enable_write |=> wd_running_ff && $stable(cnt_ff))
		else $error("watchdog did not start");
	chk_wd_hold: assert property (seq_running_hold |=> wd_running_ff)
		else $error("watchdog stopped");
	chk_wdt_read: assert property (
		(rf_req.rd && rf_req.addr == ITW_WATCHDOG_MODE_ADDR) |=> rf_rdata_ff == ITW_MODE_RESET)
		else $error("watchdog register read nonzero");
	chk_restart_clear: assert property ((wd_restart && !carry) |=> !scaler_ff)
		else $error("restart left carry");
	chk_idle_scaler: assert property (!wd_running_ff |-> !scaler_ff)
		else $error("scaler set while idle");
	chk_expire_reset: assert property (
		(wd_running_ff && scaler_ff && cnt_ff == ITW_WD_EXPIRE_LOW) |=> wd_sys_reset_ff [*2])
		else $error("no reset at count 192");
endmodule : itw_timer
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bench for the interval timer and watchdog, driven at falling edges
module tb_top import itw_pkg::*;;
	logic core_clk = 1'b0; // 200 MHz system clock
	logic rst = 1'b1; // Synchronous reset, held at start
	itw_rf_req_s req = '0; // Register file request
	logic tm0 = 1'b0; // Timer 0 count-up stimulus
	logic pin = 1'b0; // Interrupt pin level
	logic zce = 1'b0; // Zero-cross routing select
	logic zco = 1'b0; // Zero-cross detector output
	wire logic [3:0] rdata; // Registered read data
	wire logic irq; // Interval request pulse
	wire logic run; // Watchdog running level
	wire logic sysrst; // System reset request
	int fail_count = 0; // Mismatches seen
	int check_count = 0; // Comparisons made
	int irq_count = 0; // Interval requests seen so far
	// Clock, half period 2.5 ns
	always #2.5 core_clk = ~core_clk;
	// ==========================================================
	// Device under test
	itw_timer i_dut (.core_clk(core_clk), .rst(rst), .rf_req(req), .rf_rdata_ff(rdata),
		.tm0_count_up(tm0), .int_pin(pin), .zero_cross_enable(zce), .zero_cross_out(zco),
		.interval_irq_ff(irq), .wd_running_ff(run), .wd_sys_reset_ff(sysrst));
	// Count one-cycle requests; a stuck-high pulse shows up as extra counts
	always @(posedge core_clk) if (irq === 1'b1) irq_count <= irq_count + 1;
	// ==========================================================
	// Comparison and closing
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	// ==========================================================
	// Register access; each task starts and ends at a falling edge
	task wr(input logic [6:0] a, input logic [3:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge core_clk);
		req = '0;
		@(negedge core_clk);
	endtask : wr
	task rd(input logic [6:0] a, input logic [3:0] exp, input string what);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge core_clk);
		req = '0;
		chk(what, 8'(rdata), 8'(exp));
		@(negedge core_clk);
	endtask : rd
	// Pulses: sel bit 0 timer 0, bit 1 pin, bit 2 zero-cross; one high, one low cycle
	task pulse(input logic [2:0] sel, input int n);
		repeat (n) begin
			{zco, pin, tm0} = sel;
			@(negedge core_clk);
			{zco, pin, tm0} = 3'h0;
			@(negedge core_clk);
		end
	endtask : pulse
	// Hang guard, far beyond the sequence length
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		rd(ITW_INTERVAL_TIMER_MODE_ADDR, 4'h0, "itm reset");
		rd(ITW_WATCHDOG_MODE_ADDR, 4'h0, "wdm reset");
		chk("run reset", 8'(run), 8'h00);
		wr(ITW_INTERVAL_TIMER_MODE_ADDR, 4'h6);
		rd(ITW_INTERVAL_TIMER_MODE_ADDR, 4'h2, "clear reads zero");
		pulse(3'h1, 127);
		chk("irq at 127", 8'(irq_count), 8'h00);
		pulse(3'h1, 1);
		chk("irq at 128", 8'(irq_count), 8'h01);
		wr(ITW_INTERVAL_TIMER_MODE_ADDR, 4'hA);
		pulse(3'h1, 31);
		chk("irq at 31", 8'(irq_count), 8'h01);
		pulse(3'h1, 1);
		chk("irq at 32", 8'(irq_count), 8'h02);
		// Repeated clears keep the interval from ever completing
		// clear before 128
		wr(ITW_INTERVAL_TIMER_MODE_ADDR, 4'h6);
		pulse(3'h1, 127);
		wr(ITW_INTERVAL_TIMER_MODE_ADDR, 4'h6);
		pulse(3'h1, 127);
		chk("irq cleared", 8'(irq_count), 8'h02);
		wr(7'h23, 4'hF);
		rd(7'h23, 4'h0, "unmapped");
		rd(ITW_INTERVAL_TIMER_MODE_ADDR, 4'h2, "itm kept");
		// Pin source, short interval, then via the zero-cross path
		wr(ITW_INTERVAL_TIMER_MODE_ADDR, 4'hF);
		pulse(3'h2, 32);
		chk("irq pin", 8'(irq_count), 8'h03);
		zce = 1'b1;
		pulse(3'h2, 32);
		chk("pin bypassed", 8'(irq_count), 8'h03);
		pulse(3'h4, 32);
		chk("irq zero cross", 8'(irq_count), 8'h04);
		zce = 1'b0;
		// Divider sources ignore timer 0; full divider periods are too long to run here
		for (int i = 0; i < 2; i++) begin
			wr(ITW_INTERVAL_TIMER_MODE_ADDR, 4'hC | 4'(i));
			pulse(3'h1, 40);
			chk("divider source", 8'(irq_count), 8'h04);
		end
		// Watchdog: enable mid-count, the counter must carry on from 100
		wr(ITW_INTERVAL_TIMER_MODE_ADDR, 4'h6);
		pulse(3'h1, 100);
		wr(ITW_WATCHDOG_MODE_ADDR, 4'h1);
		chk("run on", 8'(run), 8'h01);
		rd(ITW_WATCHDOG_MODE_ADDR, 4'h0, "wdm reads zero");
		pulse(3'h1, 28);
		chk("irq after enable", 8'(irq_count), 8'h05);
		wr(ITW_WATCHDOG_MODE_ADDR, 4'h0);
		chk("run stays", 8'(run), 8'h01);
		pulse(3'h1, 63);
		chk("no reset at 191", 8'(sysrst), 8'h00);
		wr(ITW_WATCHDOG_MODE_ADDR, 4'h8);
		pulse(3'h1, 128);
		chk("restart holds off", 8'(sysrst), 8'h00);
		pulse(3'h1, 1);
		chk("reset at 192", 8'(sysrst), 8'h01);
		// Device reset in mid-run stops the watchdog and clears modes
		rst = 1'b1;
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		chk("run after rst", 8'(run), 8'h00);
		chk("reset after rst", 8'(sysrst), 8'h00);
		rd(ITW_INTERVAL_TIMER_MODE_ADDR, 4'h0, "itm after rst");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
